//--- shared/fpes_map.svh
// Constants of the flash program, erase and security block.
// Assumes a 100 MHz system clock and an 8-bit special-register bus.
`ifndef FPES_MAP_SVH
`define FPES_MAP_SVH

// ----------------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------------
`define FPES_ADDR_PROG_CTRL     8'h8f
`define FPES_ADDR_TIMING_CTRL   8'hb6
`define FPES_ADDR_LIMIT_HIGH    8'hb7
`define FPES_RST_PROG_CTRL      8'h00
`define FPES_RST_TIMING_CTRL    8'h8f
`define FPES_RST_LIMIT_HIGH     8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FPES_BIT_WRITE_EN       0
`define FPES_BIT_ERASE_EN       1
`define FPES_PRESCALE_OFF       4'hf

// ----------------------------------------------------------------------
// Memory layout
// ----------------------------------------------------------------------
`define FPES_MEM_WORDS          32896
`define FPES_MAIN_END           16'h7e00
`define FPES_SCRATCH_BASE       16'h8000
`define FPES_SCRATCH_LAST       16'h807f
`define FPES_SECTOR_MASK        16'hfe00
`define FPES_MASS_LAST          16'h7dff
`define FPES_LOCK_SECTOR        16'h7c00
`define FPES_READ_LOCK_ADDR     16'h7dff
`define FPES_WRITE_LOCK_ADDR    16'h7dfe
`define FPES_ERASED_BYTE        8'hff

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FPES_OP_TIME_US         10000
`define FPES_TICK_US            20

`endif

//--- shared/fpes_pkg.sv
// Types of the flash program, erase and security block.
// Assumes fpes_map.svh carries the numeric constants.
package fpes_pkg;

    typedef enum logic [1:0] {
        FPES_IDLE = 2'b00,
        FPES_FILL = 2'b01,
        FPES_WAIT = 2'b11
    } fpes_state_t;

endpackage : fpes_pkg

//--- rtl/fpes_flash_ctrl.sv
// Flash sequencer: software program and erase, debug-port access, locks and read limit.
// Assumes core and debug requests are synchronous to clk_sys and one cycle long.
//
// How it works
// - Software flash writes act only while the write enable bit is set.
// - A byte program stores old byte AND new byte.
// - Erase fills a whole 512-byte main sector with 0xff.
// - With erase enable set, a write erases its sector and drops the data.
// - Erase enable stays set until software clears it.
// - Operations are timed from the 4-bit prescale; 1111b blocks them all.
// - The core stalls for the whole program or erase.
// - The 128-byte scratch sector at 0x8000 programs and erases on its own.
// - Lock bytes at 0x7dff (read) and 0x7dfe (write/erase) guard 4 kbyte blocks.
// - Lock bit n covers block n; bit 7 stops at 0x7dfd.
// - A zero read-lock bit refuses debug reads of its block.
// - A zero write-lock bit refuses debug writes and erases of its block.
// - Software may not erase the sector holding the lock bytes.
// - Lock bytes stay readable and clearable whatever their block's locks.
// - A debug erase of the lock sector erases all program memory.
// - The read limit is the limit register value followed by a zero byte.
// - Code at or above the limit reads zero below it and cannot write there.
// - Code below the limit, and instruction fetches, are unrestricted.
// - The limit resets to zero, so all memory is readable.
// - Control bits 7 to 2 read zero and ignore writes.
// - The limit register takes only its first write after reset.
`timescale 1ns/1ps
`include "fpes_map.svh"

module fpes_flash_ctrl #(
    parameter int unsigned OP_TICKS = `FPES_OP_TIME_US / `FPES_TICK_US
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic [15:0] core_pc,
    input  wire logic [15:0] core_addr,
    input  wire logic        core_rd,
    input  wire logic        core_fetch,
    input  wire logic        core_wr,
    input  wire logic [7:0]  core_wdata,
    output logic      [7:0]  core_rdata,
    output logic             core_rvalid,
    output logic             core_stall,
    input  wire logic [15:0] jtag_addr,
    input  wire logic        jtag_rd,
    input  wire logic        jtag_wr,
    input  wire logic        jtag_erase,
    input  wire logic [7:0]  jtag_wdata,
    output logic      [7:0]  jtag_rdata,
    output logic             jtag_done,
    output logic             jtag_refused
);

    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------
    logic [7:0]            mem [0:`FPES_MEM_WORDS-1];
    logic                  write_en_reg;
    logic                  erase_en_reg;
    logic [7:0]            timing_reg;
    logic [7:0]            limit_reg;
    logic                  limit_set_reg;
    fpes_pkg::fpes_state_t state_reg;
    logic [15:0]           fill_addr_reg;
    logic [15:0]           fill_last_reg;
    logic [15:0]           prog_addr_reg;
    logic [7:0]            prog_data_reg;
    logic                  prog_go_reg;
    logic [31:0]           wait_cnt_reg;
    logic                  from_jtag_reg;

    logic        busy;
    logic [3:0]  prescale;
    logic [15:0] read_limit;
    logic        ops_allowed;
    logic        core_low_guard;
    logic        core_start;
    logic        core_erase;
    logic        core_prog;
    logic        jt_prog;
    logic        jt_erase;
    logic        jt_mass;
    logic        jt_wr_refused;
    logic        start;
    logic        start_fill;
    logic [15:0] start_addr;
    logic [15:0] fill_base;
    logic [15:0] fill_last;
    logic [7:0]  read_lock;
    logic [7:0]  write_lock;

    function automatic logic fpes_in_range(input logic [15:0] a);
        fpes_in_range = (a < `FPES_MAIN_END) ||
                        (a >= `FPES_SCRATCH_BASE && a <= `FPES_SCRATCH_LAST);
    endfunction : fpes_in_range

    // Addresses past the lock bytes carry no lock bit of their own.
    function automatic logic fpes_unlocked(input logic [15:0] a, input logic [7:0] lk);
        if (a > `FPES_MASS_LAST)
            fpes_unlocked = 1'b1;
        else
            fpes_unlocked = lk[a[14:12]];
    endfunction : fpes_unlocked

    function automatic logic fpes_is_lock_byte(input logic [15:0] a);
        fpes_is_lock_byte = (a == `FPES_READ_LOCK_ADDR) || (a == `FPES_WRITE_LOCK_ADDR);
    endfunction : fpes_is_lock_byte

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    assign busy        = (state_reg != fpes_pkg::FPES_IDLE) || prog_go_reg;
    assign core_stall  = busy;
    assign prescale    = timing_reg[3:0];
    assign ops_allowed = (prescale != `FPES_PRESCALE_OFF);
    assign read_limit  = {limit_reg, 8'h00};
    assign read_lock   = mem[`FPES_READ_LOCK_ADDR];
    assign write_lock  = mem[`FPES_WRITE_LOCK_ADDR];

    // Code running in the upper partition may not touch the lower one.
    assign core_low_guard = (core_pc >= read_limit) && (core_addr < read_limit);

    assign core_start = core_wr && !busy && !jtag_wr && !jtag_erase && write_en_reg &&
                        ops_allowed && fpes_in_range(core_addr) && !core_low_guard;
    assign core_erase = core_start && erase_en_reg &&
                        ((core_addr & `FPES_SECTOR_MASK) != `FPES_LOCK_SECTOR);
    assign core_prog  = core_start && !erase_en_reg;

    assign jt_mass  = jtag_erase && !busy && ops_allowed &&
                      ((jtag_addr & `FPES_SECTOR_MASK) == `FPES_LOCK_SECTOR);
    assign jt_erase = jtag_erase && !busy && ops_allowed && !jt_mass &&
                      fpes_in_range(jtag_addr) && fpes_unlocked(jtag_addr, write_lock);
    assign jt_prog  = jtag_wr && !busy && ops_allowed && fpes_in_range(jtag_addr) &&
                      (fpes_is_lock_byte(jtag_addr) ||
                       fpes_unlocked(jtag_addr, write_lock));
    assign jt_wr_refused = (jtag_wr || jtag_erase) && !jt_prog && !jt_erase && !jt_mass;

    assign start_fill = core_erase || jt_erase || jt_mass;
    assign start      = start_fill || core_prog || jt_prog;
    assign start_addr = (jtag_wr || jtag_erase) ? jtag_addr : core_addr;

    always_comb
    begin
        fill_base = start_addr & `FPES_SECTOR_MASK;
        fill_last = fill_base | 16'h01ff;
        if (jt_mass)
        begin
            fill_base = 16'h0000;
            fill_last = `FPES_MASS_LAST;
        end
        else if (start_addr >= `FPES_SCRATCH_BASE)
        begin
            fill_base = `FPES_SCRATCH_BASE;
            fill_last = `FPES_SCRATCH_LAST;
        end
    end

    // ------------------------------------------------------------------
    // Special registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            write_en_reg <= 1'b0;
            erase_en_reg <= 1'b0;
            timing_reg   <= `FPES_RST_TIMING_CTRL;
        end
        else if (sfr_wr && sfr_addr == `FPES_ADDR_PROG_CTRL)
        begin
            write_en_reg <= sfr_wdata[`FPES_BIT_WRITE_EN];
            erase_en_reg <= sfr_wdata[`FPES_BIT_ERASE_EN];
        end
        else if (sfr_wr && sfr_addr == `FPES_ADDR_TIMING_CTRL)
        begin
            timing_reg <= {sfr_wdata[7:6], 2'b00, sfr_wdata[3:0]};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            limit_reg     <= `FPES_RST_LIMIT_HIGH;
            limit_set_reg <= 1'b0;
        end
        else if (sfr_wr && sfr_addr == `FPES_ADDR_LIMIT_HIGH && !limit_set_reg)
        begin
            limit_reg     <= sfr_wdata;
            limit_set_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            sfr_rdata <= 8'h00;
        else
        begin
            unique case (sfr_addr)
                `FPES_ADDR_PROG_CTRL:   sfr_rdata <= {6'b000000, erase_en_reg, write_en_reg};
                `FPES_ADDR_TIMING_CTRL: sfr_rdata <= timing_reg;
                `FPES_ADDR_LIMIT_HIGH:  sfr_rdata <= limit_reg;
                default:                sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // The wait scales the tick count by two to the prescale code, so each
    // code keeps the operation time near constant over its clock range.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg     <= fpes_pkg::FPES_IDLE;
            fill_addr_reg <= 16'h0000;
            fill_last_reg <= 16'h0000;
            prog_addr_reg <= 16'h0000;
            prog_data_reg <= 8'h00;
            prog_go_reg   <= 1'b0;
            wait_cnt_reg  <= 32'h0000_0000;
            from_jtag_reg <= 1'b0;
        end
        else
        begin
            prog_go_reg <= 1'b0;
            unique case (state_reg)
                fpes_pkg::FPES_IDLE:
                begin
                    if (start)
                    begin
                        from_jtag_reg <= jtag_wr || jtag_erase;
                        wait_cnt_reg  <= (32'(OP_TICKS) << prescale) - 32'h1;
                        fill_addr_reg <= fill_base;
                        fill_last_reg <= fill_last;
                        prog_addr_reg <= start_addr;
                        prog_data_reg <= jtag_wr ? jtag_wdata : core_wdata;
                        prog_go_reg   <= !start_fill;
                        state_reg     <= start_fill ? fpes_pkg::FPES_FILL
                                                    : fpes_pkg::FPES_WAIT;
                    end
                end
                fpes_pkg::FPES_FILL:
                begin
                    fill_addr_reg <= fill_addr_reg + 16'h1;
                    if (fill_addr_reg == fill_last_reg)
                        state_reg <= fpes_pkg::FPES_WAIT;
                end
                fpes_pkg::FPES_WAIT:
                begin
                    wait_cnt_reg <= wait_cnt_reg - 32'h1;
                    if (wait_cnt_reg == 32'h0)
                        state_reg <= fpes_pkg::FPES_IDLE;
                end
            endcase
        end
    end

    // Flash cells keep their contents through reset.
    always_ff @(posedge clk_sys)
    begin
        if (state_reg == fpes_pkg::FPES_FILL)
            mem[fill_addr_reg] <= `FPES_ERASED_BYTE;
        else if (prog_go_reg)
            mem[prog_addr_reg] <= mem[prog_addr_reg] & prog_data_reg;
    end

    // ------------------------------------------------------------------
    // Read paths and answers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            core_rdata  <= 8'h00;
            core_rvalid <= 1'b0;
        end
        else
        begin
            core_rvalid <= core_rd && !busy;
            if (core_rd && !busy)
            begin
                if (!fpes_in_range(core_addr) && core_addr < `FPES_MAIN_END)
                    core_rdata <= 8'h00;
                else if (core_addr > `FPES_SCRATCH_LAST)
                    core_rdata <= 8'h00;
                else if (!core_fetch && core_low_guard)
                    core_rdata <= 8'h00;
                else
                    core_rdata <= mem[core_addr];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            jtag_rdata   <= 8'h00;
            jtag_done    <= 1'b0;
            jtag_refused <= 1'b0;
        end
        else
        begin
            jtag_done    <= (jtag_rd && !busy) ||
                            (state_reg == fpes_pkg::FPES_WAIT && wait_cnt_reg == 32'h0 &&
                             from_jtag_reg);
            jtag_refused <= !busy && (jt_wr_refused ||
                            (jtag_rd && !fpes_is_lock_byte(jtag_addr) &&
                             !fpes_unlocked(jtag_addr, read_lock)));
            if (jtag_rd && !busy)
            begin
                if (jtag_addr > `FPES_SCRATCH_LAST)
                    jtag_rdata <= 8'h00;
                else if (fpes_is_lock_byte(jtag_addr) ||
                         fpes_unlocked(jtag_addr, read_lock))
                    jtag_rdata <= mem[jtag_addr];
                else
                    jtag_rdata <= 8'h00;
            end
        end
    end

endmodule : fpes_flash_ctrl

//--- tb/fpes_flash_ctrl_props.sv
// Port checker of the flash sequencer.
// Assumes it is bound to fpes_flash_ctrl and is handed its OP_TICKS.
`timescale 1ns/1ps

module fpes_flash_ctrl_props #(
    parameter int unsigned OP_TICKS = 2
) (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic [7:0]  sfr_rdata,
    input wire logic [15:0] core_pc,
    input wire logic [15:0] core_addr,
    input wire logic        core_rd,
    input wire logic        core_wr,
    input wire logic        core_rvalid,
    input wire logic        core_stall,
    input wire logic        jtag_rd,
    input wire logic        jtag_wr,
    input wire logic        jtag_erase,
    input wire logic [7:0]  jtag_rdata,
    input wire logic        jtag_done,
    input wire logic        jtag_refused
);
    // ------------------------------------------------------------
    // Shadows
    // ------------------------------------------------------------
    logic [1:0] en_reg;
    logic       off_reg;
    int         cnt_reg;
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            {en_reg, off_reg} <= 3'h1;
        else if (sfr_wr && sfr_addr == 8'h8f)
            en_reg <= sfr_wdata[1:0];
        else if (sfr_wr && sfr_addr == 8'hb6)
            off_reg <= sfr_wdata[3:0] == 4'hf;
    end
    // Counting stall cycles lets a too short operation be caught.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            cnt_reg <= 0;
        else
            cnt_reg <= core_stall ? cnt_reg + 1 : 0;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    property p_rd; core_rd && !core_stall |=> core_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_ctl; sfr_addr == 8'h8f |=> sfr_rdata[7:2] == 6'h00; endproperty
    a_ctl: assert property (p_ctl) else $error("control high bits set");
    property p_idle; core_wr && en_reg == 2'h0 && !core_stall && !jtag_wr && !jtag_erase
        |=> !core_stall; endproperty
    a_idle: assert property (p_idle) else $error("write ran while disabled");
    property p_off; core_wr && off_reg && !core_stall |=> !core_stall; endproperty
    a_off: assert property (p_off) else $error("write ran with prescale off");
    property p_len; $fell(core_stall) && cnt_reg != 0 |-> cnt_reg >= OP_TICKS; endproperty
    a_len: assert property (p_len) else $error("stall too short");
    property p_go; core_wr && !core_stall && en_reg == 2'h1 && !off_reg && !jtag_wr
        && !jtag_erase && core_pc == 16'h0000 && core_addr < 16'h7e00 |=> core_stall;
    endproperty
    a_go: assert property (p_go) else $error("program did not start");
    property p_jrd; jtag_rd && !core_stall |=> jtag_done; endproperty
    a_jrd: assert property (p_jrd) else $error("debug read not answered");
    property p_jz; jtag_done && jtag_refused |-> jtag_rdata == 8'h00; endproperty
    a_jz: assert property (p_jz) else $error("locked read gave data");
    property p_joff; (jtag_wr || jtag_erase) && !core_stall && off_reg
        |=> jtag_refused && !jtag_done; endproperty
    a_joff: assert property (p_joff) else $error("debug write with prescale off");
    c_erase: cover property (core_wr && en_reg == 2'h3 ##1 core_stall);
    c_refused: cover property (jtag_refused);
    c_long: cover property ($fell(core_stall) && cnt_reg > 500);
endmodule : fpes_flash_ctrl_props

bind fpes_flash_ctrl fpes_flash_ctrl_props #(.OP_TICKS(OP_TICKS)) i_props (
    .clk_sys, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .core_pc, .core_addr,
    .core_rd, .core_wr, .core_rvalid, .core_stall, .jtag_rd, .jtag_wr, .jtag_erase,
    .jtag_rdata, .jtag_done, .jtag_refused
);

//--- tb/fpes_host_model.sv
// Stand-in for the processor core and the debug controller.
// Assumes one task call at a time; requests change at falling edges.
`timescale 1ns/1ps

module fpes_host_model (
    input  wire logic        clk_sys,
    input  wire logic        core_stall,
    output logic      [15:0] core_pc,
    output logic      [15:0] core_addr,
    output logic             core_rd,
    output logic             core_fetch,
    output logic             core_wr,
    output logic      [7:0]  core_wdata,
    output logic      [15:0] jtag_addr,
    output logic             jtag_rd,
    output logic             jtag_wr,
    output logic             jtag_erase,
    output logic      [7:0]  jtag_wdata
);
    // ------------------------------------------------------------
    // Request tasks
    // ------------------------------------------------------------
    initial
    begin
        {core_pc, core_addr, core_rd, core_fetch, core_wr, core_wdata} = '0;
        {jtag_addr, jtag_rd, jtag_wr, jtag_erase, jtag_wdata} = '0;
    end
    // A request made during a stall is dropped, so the host waits.
    task automatic wait_free(input int cap);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (core_stall && n < cap)
        begin
            @(negedge clk_sys);
            n++;
        end
    endtask : wait_free
    task automatic core_op(input logic wr, input logic fch, input logic [15:0] pc,
                           input logic [15:0] ad, input logic [7:0] d);
        wait_free(40000);
        core_pc = pc;
        core_addr = ad;
        core_fetch = fch;
        core_wdata = d;
        {core_rd, core_wr} = {!wr, wr};
        @(negedge clk_sys);
        {core_rd, core_wr} = 2'b00;
        // Released data is inverted so a stale byte cannot pass for a live one.
        core_wdata = ~d;
    endtask : core_op
    task automatic jtag_op(input logic [2:0] k, input logic [15:0] ad, input logic [7:0] d);
        wait_free(40000);
        jtag_addr = ad;
        jtag_wdata = d;
        {jtag_rd, jtag_wr, jtag_erase} = k;
        @(negedge clk_sys);
        {jtag_rd, jtag_wr, jtag_erase} = 3'b000;
        jtag_wdata = ~d;
    endtask : jtag_op
endmodule : fpes_host_model

//--- tb/test_flash_program_erase_security.sv
// Self-checking bench of the flash sequencer against a reference memory.
// Assumes the host model makes core and debug requests.
`timescale 1ns/1ps

module test_flash_program_erase_security;
    logic        clk_sys = 1'b0;
    logic        rstn, sfr_wr, core_rd, core_fetch, core_wr, core_rvalid, core_stall;
    logic        jtag_rd, jtag_wr, jtag_erase, jtag_done, jtag_refused;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, core_wdata, core_rdata, jtag_wdata, jtag_rdata;
    logic [15:0] core_pc, core_addr, jtag_addr;
    int          err_total = 0, cmp_count = 0, lim = 0, lim_set = 0, en = 0, off = 1;
    int          tim = 'h8f, a, i, n;
    int          mref [int];
    always #5 clk_sys = ~clk_sys;
    fpes_flash_ctrl #(.OP_TICKS(2)) i_dut (
        .clk_sys, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .core_pc, .core_addr,
        .core_rd, .core_fetch, .core_wr, .core_wdata, .core_rdata, .core_rvalid, .core_stall,
        .jtag_addr, .jtag_rd, .jtag_wr, .jtag_erase, .jtag_wdata, .jtag_rdata, .jtag_done,
        .jtag_refused
    );
    fpes_host_model i_host (
        .clk_sys, .core_stall, .core_pc, .core_addr, .core_rd, .core_fetch, .core_wr,
        .core_wdata, .jtag_addr, .jtag_rd, .jtag_wr, .jtag_erase, .jtag_wdata
    );
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk8(input string what, input int exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp[7:0])
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp[7:0], got);
        end
    endtask : chk8
    task automatic sfr_w(input int ad, input int d);
        @(negedge clk_sys);
        {sfr_addr, sfr_wdata, sfr_wr} = {ad[7:0], d[7:0], 1'b1};
        if (ad == 'h8f)
            en = d & 3;
        if (ad == 'hb6)
            tim = d & 'hcf;
        off = (tim & 'hf) == 'hf;
        if (ad == 'hb7 && !lim_set)
            lim = (d & 'hff) << 8;
        lim_set = lim_set | (ad == 'hb7);
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask : sfr_w
    task automatic sfr_r(input int ad);
        @(negedge clk_sys);
        sfr_addr = ad[7:0];
        repeat (2) @(negedge clk_sys);
        chk8("register", ad == 'h8f ? en : ad == 'hb6 ? tim : ad == 'hb7 ? lim >> 8 : 0, sfr_rdata);
    endtask : sfr_r
    task automatic rd(input int pc, input int ad, input int f);
        i_host.core_op(1'b0, f[0], pc[15:0], ad[15:0], 8'h00);
        chk8("read valid", 1, {7'h00, core_rvalid});
        chk8("read data", (ad > 'h807f || (!f && pc >= lim && ad < lim)) ? 0 : mref[ad],
             core_rdata);
    endtask : rd
    task automatic wr(input int pc, input int ad, input int d);
        int ok;
        int b;
        ok = en[0] && !off && (ad < 'h7e00 || (ad >= 'h8000 && ad <= 'h807f))
             && !(pc >= lim && ad < lim) && !(en == 3 && ad >= 'h7c00 && ad < 'h7e00);
        i_host.core_op(1'b1, 1'b0, pc[15:0], ad[15:0], d[7:0]);
        chk8("stall", ok, {7'h00, core_stall});
        b = ad >= 'h8000 ? 'h8000 : ad & 'hfe00;
        if (ok && en == 3)
            for (int k = b; k < b + (b == 'h8000 ? 128 : 512); k++)
                mref[k] = 'hff;
        else if (ok)
            mref[ad] = mref[ad] & d;
        i_host.wait_free(2000);
        // A stall that never ends must not slip through as a quiet timeout.
        chk8("stall end", 0, {7'h00, core_stall});
    endtask : wr
    // Kind is {read, write, erase}; expectations come from the lock bytes in the model.
    task automatic jt(input int k, input int ad, input int d);
        int r;
        r = (k != 4 && off) || (ad < 'h7dfe
            && !((mref[k == 4 ? 'h7dff : 'h7dfe] >> ((ad >> 12) & 7)) & 1));
        if (k == 1 && ad >= 'h7c00 && ad < 'h7e00)
            r = off;
        i_host.jtag_op(k[2:0], ad[15:0], d[7:0]);
        n = 0;
        while (!jtag_done && !jtag_refused && n < 40000)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk8("debug answer", 1, {7'h00, jtag_done || jtag_refused});
        chk8("refused", r, {7'h00, jtag_refused});
        if (k == 4)
            chk8("debug data", r ? 0 : mref[ad], jtag_rdata);
        if (k == 2 && !r)
            mref[ad] = mref[ad] & d;
        if (k == 1 && !r)
            for (int m = 0; m < 'h7e00; m++)
                mref[m] = 'hff;
    endtask : jt
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        err_total++;
        stop_test();
    end
    initial
    begin
        {rstn, sfr_wr, sfr_addr, sfr_wdata} = '0;
        n = $urandom(32'hd504);
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        sfr_r('h8f);
        sfr_r('hb6);
        sfr_r('hb7);
        sfr_r('h55);
        sfr_w('h8f, 'hff);
        sfr_r('h8f);
        wr(0, 'h0100, 0);
        jt(2, 'h0100, 0);
        sfr_w('hb6, 'h80);
        jt(1, 'h7c00, 0);
        rd(0, 'h1234, 0);
        sfr_w('h8f, 0);
        wr(0, 'h0100, 0);
        rd(0, 'h0100, 0);
        $display("test registers and enables done");
        sfr_w('h8f, 1);
        for (i = 0; i < 6; i++)
        begin
            a = $urandom % 'h7c00;
            wr(0, a, $urandom);
            wr(0, a, $urandom);
            rd(0, a, 0);
        end
        wr(0, 'h0201, 0);
        wr(0, 'h0401, 0);
        sfr_w('h8f, 3);
        wr(0, 'h0300, 'h55);
        rd(0, 'h0201, 0);
        rd(0, 'h03ff, 0);
        wr(0, 'h0555, 0);
        rd(0, 'h0401, 0);
        wr(0, 'h7d00, 0);
        wr(0, 'h8000, 0);
        sfr_w('h8f, 1);
        wr(0, 'h807f, 'h5a);
        rd(0, 'h807f, 0);
        rd(0, 'h8000, 0);
        $display("test program and erase done");
        jt(2, 'h7dfe, 'hfe);
        jt(2, 'h0010, 0);
        jt(2, 'h1010, 'h0f);
        jt(2, 'h7dff, 'h7f);
        jt(4, 'h7010, 0);
        jt(4, 'h7dfd, 0);
        jt(4, 'h7dff, 0);
        jt(4, 'h6fff, 0);
        $display("test locks done");
        sfr_w('hb7, 'h40);
        sfr_w('hb7, 'h10);
        sfr_r('hb7);
        rd('h5000, 'h3fff, 0);
        rd('h5000, 'h4000, 0);
        rd('h5000, 'h0100, 1);
        rd('h1000, 'h0100, 0);
        wr('h5000, 'h0201, 0);
        $display("test limit done");
        stop_test();
    end
endmodule : test_flash_program_erase_security
